// ---- wit_pkg.sv ----
// Constants and register map of the watch/interval timer
package wit_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [15:0] WIT_MODE_IDX = 16'hff4a;
	localparam logic [15:0] WIT_PSEL_IDX = 16'hff4b;
	localparam logic [19:0] WIT_MODE_ADDR = {2'b00, WIT_MODE_IDX, 2'b00};
	localparam logic [19:0] WIT_PSEL_ADDR = {2'b00, WIT_PSEL_IDX, 2'b00};
	// Added registers for events and bit-wise mode access
	localparam logic [19:0] WIT_STAT_ADDR = 20'h3_fd30;
	localparam logic [19:0] WIT_CLR_ADDR = 20'h3_fd34;
	localparam logic [19:0] WIT_IEN_ADDR = 20'h3_fd38;
	localparam logic [19:0] WIT_BITW_ADDR = 20'h3_fd3c;

	// Mode register fields
	localparam int WIT_CLKSEL_BIT = 7;
	localparam int WIT_IVL_LSB = 4;
	localparam int WIT_RUN_BIT = 1;
	localparam int WIT_EN_BIT = 0;
	localparam logic [7:0] WIT_MODE_MASK = 8'hf3;
	localparam logic [7:0] WIT_MODE_RST = 8'h00;
	localparam logic WIT_PSEL_RST = 1'b0;
	localparam logic [2:0] WIT_IVL_MAX = 3'h5;

	// Event bits in status, clear and enable registers
	localparam int WIT_EV_WATCH = 0;
	localparam int WIT_EV_IVL = 1;
	localparam logic [1:0] WIT_EV_RST = 2'h0;

	// Timing: main clock divider and timer widths
	localparam int WIT_MAIN_DIV = 128;
	localparam int WIT_DIV_W = $clog2(WIT_MAIN_DIV);
	localparam int WIT_PRE_W = 9;
	localparam int WIT_CNT_W = 5;
	localparam int WIT_TAP_BASE = 4;

endpackage

// ---- wit_sync_edge.sv ----
// Two-flop synchroniser with rising-edge detector for a pin input
`timescale 1ns/100ps
module wit_sync_edge
	import wit_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic async_in,
	output logic rise
);

	logic meta_r; // First stage, read only by the second
	logic sync_r; // Second stage, safe to use
	logic last_r; // Previous synced level
	logic meta_nxt;
	logic sync_nxt;
	logic last_nxt;

	// Next values of the shift chain
	always_comb
	begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
		last_nxt = sync_r;
	end

	// Register the chain
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			last_r <= last_nxt;
		end
	end

	// Edge seen only past the second stage
	assign rise = sync_r & ~last_r;

endmodule

// ---- wit_top.sv ----
// Watch timer with interval timer, APB register slave and interrupt
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module wit_top
	import wit_pkg::*;
#(
	parameter int ADDR_W = 20
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sub_clk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic watch_period_irq,
	output logic interval_period_irq
);

	// Mode register and its decoded fields
	logic [7:0] watch_mode_control_r;
	logic [7:0] watch_mode_control_nxt;
	logic half_rate_period_sel_r; // Bit 0 of the period select register
	logic half_rate_period_sel_nxt;
	logic tick_clock_source_sel;
	logic [2:0] interval_sel;
	logic seconds_counter_run;
	logic watch_enable_bit;

	// Interrupt registers
	logic [1:0] stat_r;
	logic [1:0] stat_nxt;
	logic [1:0] ien_r;
	logic [1:0] ien_nxt;

	// Timer state
	logic [WIT_DIV_W-1:0] div_r; // Main clock divider
	logic [WIT_DIV_W-1:0] div_nxt;
	logic half_ph_r; // Phase for halving the subsystem clock
	logic half_ph_nxt;
	logic [WIT_PRE_W-1:0] pre_r; // Prescaler
	logic [WIT_PRE_W-1:0] pre_nxt;
	logic [WIT_CNT_W-1:0] cnt_r; // Seconds counter
	logic [WIT_CNT_W-1:0] cnt_nxt;
	logic wirq_r; // Watch pulse, one tick long
	logic wirq_nxt;
	logic iirq_r; // Interval pulse, one tick long
	logic iirq_nxt;

	// Bus and timing helpers
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic sub_rise;
	logic div_pulse;
	logic sub_tick;
	logic tick;
	logic pre_wrap;
	logic [WIT_PRE_W-1:0] tap_mask;
	logic watch_ev;
	logic ivl_ev;
	logic setup_ph;
	logic wr_acc;
	logic addr_hit;
	logic [ADDR_W-1:0] a_mode;
	logic [ADDR_W-1:0] a_psel;
	logic [ADDR_W-1:0] a_stat;
	logic [ADDR_W-1:0] a_clr;
	logic [ADDR_W-1:0] a_ien;
	logic [ADDR_W-1:0] a_bitw;

	// Subsystem clock arrives on a pin; synchronised before use
	wit_sync_edge u_sub_sync (
		.clk(mclk),
		.rst(sys_rst),
		.async_in(sub_clk),
		.rise(sub_rise)
	);

	// Address constants cut to the bus width
	assign a_mode = ADDR_W'(WIT_MODE_ADDR);
	assign a_psel = ADDR_W'(WIT_PSEL_ADDR);
	assign a_stat = ADDR_W'(WIT_STAT_ADDR);
	assign a_clr = ADDR_W'(WIT_CLR_ADDR);
	assign a_ien = ADDR_W'(WIT_IEN_ADDR);
	assign a_bitw = ADDR_W'(WIT_BITW_ADDR);

	// Field decode of the mode register
	assign tick_clock_source_sel = watch_mode_control_r[WIT_CLKSEL_BIT];
	assign interval_sel = watch_mode_control_r[WIT_IVL_LSB +: 3];
	assign seconds_counter_run = watch_mode_control_r[WIT_RUN_BIT];
	assign watch_enable_bit = watch_mode_control_r[WIT_EN_BIT];

	// Tick source: divided main clock or subsystem clock, maybe halved
	always_comb
	begin
		div_pulse = (div_r == WIT_DIV_W'(WIT_MAIN_DIV - 1));
		// Halving only applies with the subsystem clock selected
		sub_tick = sub_rise & (~half_rate_period_sel_r | half_ph_r);
		if (tick_clock_source_sel)
		begin
			tick = watch_enable_bit & sub_tick;
		end
		else
		begin
			tick = watch_enable_bit & div_pulse;
		end
	end

	// Interval tap: low 4+k prescaler bits all ones
	always_comb
	begin
		tap_mask = WIT_PRE_W'((10'h001 << (WIT_TAP_BASE + int'(interval_sel))) - 10'h001);
		pre_wrap = (pre_r == {WIT_PRE_W{1'b1}});
		// Same prescaler drives both functions, no interference
		ivl_ev = tick & ((pre_r & tap_mask) == tap_mask);
		// Overflow of the 5-bit counter marks the watch period
		watch_ev = tick & pre_wrap & seconds_counter_run
			& (cnt_r == {WIT_CNT_W{1'b1}});
	end

	// Next state of divider, prescaler, counter and pulses
	always_comb
	begin
		div_nxt = div_r + WIT_DIV_W'(1);
		half_ph_nxt = half_ph_r;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		wirq_nxt = wirq_r;
		iirq_nxt = iirq_r;
		if (sub_rise)
		begin
			half_ph_nxt = ~half_ph_r;
		end
		if (!watch_enable_bit)
		begin
			// Stopped: prescaler and counter held at zero
			pre_nxt = '0;
			cnt_nxt = '0;
			wirq_nxt = 1'b0;
			iirq_nxt = 1'b0;
		end
		else
		begin
			if (tick)
			begin
				pre_nxt = pre_r + WIT_PRE_W'(1);
				// Pulses last until the next tick
				wirq_nxt = watch_ev;
				iirq_nxt = ivl_ev;
			end
			if (!seconds_counter_run)
			begin
				// Counter alone cleared, prescaler keeps running
				cnt_nxt = '0;
			end
			else if (tick && pre_wrap)
			begin
				// Counter steps only at prescaler wrap, so the first
				// step comes one full prescaler period after start
				cnt_nxt = cnt_r + WIT_CNT_W'(1);
			end
		end
	end

	// Register the timer state
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			div_r <= '0;
			half_ph_r <= 1'b0;
			pre_r <= '0;
			cnt_r <= '0;
			wirq_r <= 1'b0;
			iirq_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			half_ph_r <= half_ph_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			wirq_r <= wirq_nxt;
			iirq_r <= iirq_nxt;
		end
	end

	// APB phases and decode
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	always_comb
	begin
		if (paddr == a_mode)
		begin
			addr_hit = 1'b1;
		end
		else if (paddr == a_psel)
		begin
			addr_hit = 1'b1;
		end
		else if (paddr == a_stat)
		begin
			addr_hit = 1'b1;
		end
		else if (paddr == a_clr)
		begin
			addr_hit = 1'b1;
		end
		else if (paddr == a_ien)
		begin
			addr_hit = 1'b1;
		end
		else if (paddr == a_bitw)
		begin
			addr_hit = 1'b1;
		end
		else
		begin
			addr_hit = 1'b0;
		end
	end

	// Register writes and sticky status
	always_comb
	begin
		logic [7:0] wmask;
		logic [7:0] wval;
		logic [7:0] cand;
		logic [1:0] clr;
		wmask = 8'h00;
		wval = 8'h00;
		cand = 8'h00;
		clr = 2'h0;
		watch_mode_control_nxt = watch_mode_control_r;
		half_rate_period_sel_nxt = half_rate_period_sel_r;
		ien_nxt = ien_r;
		if (wr_acc && paddr == a_mode && pstrb[0])
		begin
			// Whole-byte write
			wmask = 8'hff;
			wval = pwdata[7:0];
		end
		else if (wr_acc && paddr == a_bitw && pstrb[0] && pstrb[1])
		begin
			// Masked write: only the flagged bits change
			wmask = pwdata[15:8];
			wval = pwdata[7:0];
		end
		else if (wr_acc && paddr == a_psel && pstrb[0])
		begin
			half_rate_period_sel_nxt = pwdata[0];
		end
		else if (wr_acc && paddr == a_clr && pstrb[0])
		begin
			clr = pwdata[1:0];
		end
		else if (wr_acc && paddr == a_ien && pstrb[0])
		begin
			ien_nxt = pwdata[1:0];
		end
		cand = ((watch_mode_control_r & ~wmask) | (wval & wmask)) & WIT_MODE_MASK;
		// Prohibited interval codes are refused, field keeps old value
		if (cand[WIT_IVL_LSB +: 3] > WIT_IVL_MAX)
		begin
			cand[WIT_IVL_LSB +: 3] = interval_sel;
		end
		watch_mode_control_nxt = cand;
		// A new event wins over a clear in the same cycle
		stat_nxt = (stat_r & ~clr) | {ivl_ev, watch_ev};
	end

	// Read data captured in the setup phase
	always_comb
	begin
		prdata_nxt = prdata_r;
		if (setup_ph)
		begin
			if (paddr == a_mode)
			begin
				prdata_nxt = {24'h00_0000, watch_mode_control_r};
			end
			else if (paddr == a_psel)
			begin
				prdata_nxt = {31'h0000_0000, half_rate_period_sel_r};
			end
			else if (paddr == a_stat)
			begin
				prdata_nxt = {30'h0000_0000, stat_r};
			end
			else if (paddr == a_ien)
			begin
				prdata_nxt = {30'h0000_0000, ien_r};
			end
			else
			begin
				// Clear, bit-write and unmapped read as zero
				prdata_nxt = 32'h0000_0000;
			end
		end
	end

	// Register the software-visible state
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			watch_mode_control_r <= WIT_MODE_RST;
			half_rate_period_sel_r <= WIT_PSEL_RST;
			stat_r <= WIT_EV_RST;
			ien_r <= WIT_EV_RST;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			watch_mode_control_r <= watch_mode_control_nxt;
			half_rate_period_sel_r <= half_rate_period_sel_nxt;
			stat_r <= stat_nxt;
			ien_r <= ien_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Zero-wait slave; error only for unmapped addresses
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign prdata = prdata_r;
	// Level interrupt from enabled sticky bits
	assign irq = |(stat_r & ien_r);
	assign watch_period_irq = wirq_r;
	assign interval_period_irq = iirq_r;

endmodule

// ---- wit_top_checker.sv ----
// Port-level checker for the watch/interval timer
`timescale 1ns/100ps
module wit_top_checker
	import wit_pkg::*;
#(
	parameter int ADDR_W = 20
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sub_clk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic watch_period_irq,
	input wire logic interval_period_irq
);
	// Access phase and decode of the six mapped words
	logic acc;
	logic wr;
	logic hit;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign hit = paddr == WIT_MODE_ADDR || paddr == WIT_PSEL_ADDR || paddr == WIT_STAT_ADDR
		|| paddr == WIT_CLR_ADDR || paddr == WIT_IEN_ADDR || paddr == WIT_BITW_ADDR;

	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_ready_zero_wait: assert property (acc |-> pready)
		else $error("pready low in access");
	a_err_unmapped: assert property (acc && !hit |-> pslverr)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (acc && hit |-> !pslverr)
		else $error("error on mapped access");
	a_read_unmapped: assert property (acc && !pwrite && !hit |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !irq && !watch_period_irq && !interval_period_irq)
		else $error("outputs active after reset");
	// Only a register write or reset may drop the level interrupt
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr) || $past(sys_rst))
		else $error("irq fell without a write");
	// A write may legally cut a pulse short, so it ends the attempt
	a_watch_width: assert property (disable iff (sys_rst || wr)
		$rose(watch_period_irq) |-> watch_period_irq[*3])
		else $error("watch pulse too short");
	a_ivl_width: assert property (disable iff (sys_rst || wr)
		$rose(interval_period_irq) |-> interval_period_irq[*3])
		else $error("interval pulse too short");
	a_ivl_gap: assert property (disable iff (sys_rst || wr)
		$fell(interval_period_irq) |-> !interval_period_irq[*8])
		else $error("interval pulses too close");
	a_watch_with_ivl: assert property ($rose(watch_period_irq) |-> ##[0:1] interval_period_irq)
		else $error("watch event without interval event");

	c_watch: cover property ($rose(watch_period_irq));
	c_ivl: cover property ($rose(interval_period_irq));
	c_irq: cover property ($rose(irq));
	c_err: cover property (acc && pslverr);
endmodule

bind wit_top wit_top_checker #(.ADDR_W(ADDR_W)) i_wit_top_checker (.mclk(mclk),
	.sys_rst(sys_rst), .sub_clk(sub_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .watch_period_irq(watch_period_irq),
	.interval_period_irq(interval_period_irq));

// ---- wit_top_tb.sv ----
// Self-checking testbench for the watch/interval timer
`timescale 1ns/100ps
module wit_top_tb
	import wit_pkg::*;
;
	// Subsystem clock period in mclk cycles, kept short for run time
	localparam int SUB_CYC = 4;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic sub_clk = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [19:0] paddr = 20'h0_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, irq, watch_period_irq, interval_period_irq;
	logic [31:0] rd;
	logic serr;
	int err_count = 0;
	int num_checks = 0;
	int n;

	always #2 mclk = ~mclk;
	// Offset by 1 ns so sub clock edges never meet mclk edges
	initial
	begin
		#1;
		forever #8 sub_clk = ~sub_clk;
	end

	wit_top i_wit_top (.mclk(mclk), .sys_rst(sys_rst), .sub_clk(sub_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.watch_period_irq(watch_period_irq), .interval_period_irq(interval_period_irq));

	task automatic close_out();
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer, request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// No wait-state count assumed; only the watchdog ends a stall
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// Waits a little so the status update has landed
	task automatic irq_chk(input logic exp);
		repeat (2) @(negedge mclk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	// Edges until the next rising edge of one pulse output
	task automatic next_rise(input bit w, output int cnt);
		logic p;
		logic c;
		p = 1'b1;
		cnt = 0;
		repeat (70000)
		begin
			@(posedge mclk);
			c = w ? watch_period_irq : interval_period_irq;
			cnt++;
			if (c === 1'b1 && p === 1'b0)
				break;
			p = c;
		end
	endtask

	// First period after a change may be short; the second is judged
	task automatic ivl_period(input int exp);
		next_rise(1'b0, n);
		next_rise(1'b0, n);
		chk(32'(n), 32'(exp));
	endtask

	task automatic t_reset();
		rd_chk(WIT_MODE_ADDR, 32'h0000_0000);
		rd_chk(WIT_PSEL_ADDR, 32'h0000_0000);
		rd_chk(WIT_STAT_ADDR, 32'h0000_0000);
		rd_chk(20'h0_0010, 32'h0000_0000);
		chk({31'h0, serr}, 32'h0000_0001);
	endtask

	task automatic t_mode();
		apb(1'b1, WIT_MODE_ADDR, 32'h0000_00ff);
		rd_chk(WIT_MODE_ADDR, 32'h0000_0083);
		apb(1'b1, WIT_BITW_ADDR, 32'h0000_0100);
		rd_chk(WIT_MODE_ADDR, 32'h0000_0082);
		apb(1'b1, WIT_MODE_ADDR, 32'h0000_0031);
		rd_chk(WIT_MODE_ADDR, 32'h0000_0031);
	endtask

	// Half-rate select is set on the second pass and must not matter
	task automatic t_ivl_main();
		for (int k = 0; k < 2; k++)
		begin
			apb(1'b1, WIT_PSEL_ADDR, 32'(k));
			apb(1'b1, WIT_MODE_ADDR, 32'(k * 16 + 1));
			ivl_period((16 << k) * WIT_MAIN_DIV);
		end
	endtask

	// Every legal interval code from the subsystem clock; code 1 also halved
	task automatic t_ivl_sub();
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b1, WIT_PSEL_ADDR, 32'(k == 1));
			apb(1'b1, WIT_MODE_ADDR, 32'(32'h0000_0081 + k * 16));
			ivl_period((16 * SUB_CYC) << (k + int'(k == 1)));
		end
	endtask

	task automatic t_watch();
		apb(1'b1, WIT_PSEL_ADDR, 32'h0000_0000);
		apb(1'b1, WIT_MODE_ADDR, 32'h0000_0000);
		apb(1'b1, WIT_CLR_ADDR, 32'h0000_0003);
		apb(1'b1, WIT_IEN_ADDR, 32'h0000_0001);
		apb(1'b1, WIT_MODE_ADDR, 32'h0000_0083);
		next_rise(1'b1, n);
		chk(32'((n + 8) / 16), 32'((1 << 14) * SUB_CYC / 16));
		irq_chk(1'b1);
		apb(1'b1, WIT_IEN_ADDR, 32'h0000_0000);
		irq_chk(1'b0);
		apb(1'b1, WIT_IEN_ADDR, 32'h0000_0001);
		irq_chk(1'b1);
		apb(1'b1, WIT_CLR_ADDR, 32'h0000_0001);
		irq_chk(1'b0);
		ivl_period(16 * SUB_CYC);
		// Counter cleared alone: interval phase must not slip
		apb(1'b1, WIT_BITW_ADDR, 32'h0000_0200);
		next_rise(1'b0, n);
		chk(32'(n), 32'(16 * SUB_CYC - 3));
		rd_chk(WIT_MODE_ADDR, 32'h0000_0081);
	endtask

	initial
	begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_mode();
		t_ivl_main();
		t_ivl_sub();
		t_watch();
		close_out();
	end

	// Watchdog past the whole run, the first watch period dominating
	initial
	begin
		repeat (100000) @(posedge mclk);
		err_count++;
		close_out();
	end
endmodule
